// File: rtl/dgp_pkg.sv
/*
 * Constants and carrier types for the dual general-purpose port block.
 * Assumes a byte-wide register port on the system clock.
 */
`default_nettype none
package dgp_pkg;
    localparam int DGP_W = 8;
    localparam logic [7:0] DGP_P3_DATA_ADDR = 8'h0E;
    localparam logic [7:0] DGP_P3_DIR_ADDR = 8'h0F;
    localparam logic [7:0] DGP_P4_DATA_ADDR = 8'h10;
    localparam logic [7:0] DGP_P4_DIR_ADDR = 8'h11;
    localparam logic [7:0] DGP_P3_PU_ADDR = 8'h75;
    localparam logic [7:0] DGP_P4_PU_ADDR = 8'h76;
    localparam logic [7:0] DGP_STBY_ADDR = 8'h08;
    localparam int DGP_SPL_BIT = 0;
    localparam logic [7:0] DGP_DIR_RST = 8'h00;
    localparam logic [7:0] DGP_PU_RST = 8'h00;
    localparam logic [7:0] DGP_P4_OD_MASK = 8'h0C;
    localparam int DGP_P4_OD_LSB = 2;
    localparam int DGP_P4_OD_MSB = 3;
    localparam logic [7:0] DGP_P4_LATCH_RST_OD = 8'h0C;
    localparam logic [7:0] DGP_ZERO = 8'h00;

    // Pin group of one port: drive value, enable, pull-up
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } dgp_pins_t;

    // Peripheral sharing for one port
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] val;
    } dgp_periph_t;
endpackage
`default_nettype wire

// File: rtl/dgp_port.sv
/*
 * Two 8-bit ports with direction, output latch, pin readback, pull-up
 * control and peripheral output sharing; port four feeds external
 * interrupt inputs and has two open-drain pins.
 * Assumes pins are asynchronous, the standby mode level and peripheral
 * signals come from logic on mclk_i, and the bus follows a one-cycle
 * strobe protocol with read data in the following cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module dgp_port
    import dgp_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic bitop_rd_i,
    output logic [7:0] rdata_o,
    // Standby state (stop or watch mode active)
    input wire logic stop_watch_i,
    // Peripheral sharing
    input wire dgp_periph_t p3_periph_i,
    input wire dgp_periph_t p4_periph_i,
    // Pins
    input wire logic [7:0] p3_pin_i,
    input wire logic [7:0] p4_pin_i,
    output dgp_pins_t p3_pins_o,
    output dgp_pins_t p4_pins_o,
    // Synchronised levels to peripherals and external interrupts
    output logic [7:0] p3_level_o,
    output logic [7:0] p4_level_o,
    output logic [7:0] ext_int_o
);

    typedef struct packed {
        logic [7:0] p3_latch;
        logic [7:0] p3_dir;
        logic [7:0] p3_pu;
        logic [7:0] p4_latch;
        logic [7:0] p4_dir;
        logic [7:0] p4_pu;
        logic standby_pin_state_select;
        logic [7:0] p3_s1;
        logic [7:0] p3_s2;
        logic [7:0] p4_s1;
        logic [7:0] p4_s2;
        logic [7:0] rdata;
        dgp_pins_t p3_pins;
        dgp_pins_t p4_pins;
        logic [7:0] ext_int;
    } dgp_state_t;

    dgp_state_t st_r;
    dgp_state_t st_nxt;

    always_comb begin
        logic hiz;
        logic [7:0] v3;
        logic [7:0] v4;
        logic [7:0] p4_dir_eff;
        hiz = 1'b0;
        v3 = DGP_ZERO;
        v4 = DGP_ZERO;
        p4_dir_eff = DGP_ZERO;
        st_nxt = st_r;

        // Two-stage synchronisers on the pins
        st_nxt.p3_s1 = p3_pin_i;
        st_nxt.p3_s2 = st_r.p3_s1;
        st_nxt.p4_s1 = p4_pin_i;
        st_nxt.p4_s2 = st_r.p4_s1;

        // Register writes, bit n to pin n
        if (wr_i) begin
            case (addr_i)
                DGP_P3_DATA_ADDR: begin
                    st_nxt.p3_latch = wdata_i;
                end
                DGP_P3_DIR_ADDR: begin
                    st_nxt.p3_dir = wdata_i;
                end
                DGP_P3_PU_ADDR: begin
                    st_nxt.p3_pu = wdata_i;
                end
                DGP_P4_DATA_ADDR: begin
                    // All eight latch bits store, open-drain bits included
                    st_nxt.p4_latch = wdata_i;
                end
                DGP_P4_DIR_ADDR: begin
                    st_nxt.p4_dir = wdata_i & ~DGP_P4_OD_MASK;
                end
                DGP_P4_PU_ADDR: begin
                    st_nxt.p4_pu = wdata_i & ~DGP_P4_OD_MASK;
                end
                DGP_STBY_ADDR: begin
                    st_nxt.standby_pin_state_select = wdata_i[DGP_SPL_BIT];
                end
                default: begin
                    // Unmapped addresses take no write
                end
            endcase
        end

        // Reads: data registers show pin levels, bit ops see latches
        st_nxt.rdata = DGP_ZERO;
        if (rd_i) begin
            case (addr_i)
                DGP_P3_DATA_ADDR: begin
                    if (bitop_rd_i) begin
                        // Bit set/clear must not copy input pin levels into latches
                        st_nxt.rdata = st_r.p3_latch;
                    end else begin
                        st_nxt.rdata = st_r.p3_s2;
                    end
                end
                DGP_P3_DIR_ADDR: begin
                    st_nxt.rdata = st_r.p3_dir;
                end
                DGP_P3_PU_ADDR: begin
                    st_nxt.rdata = st_r.p3_pu;
                end
                DGP_P4_DATA_ADDR: begin
                    if (bitop_rd_i) begin
                        st_nxt.rdata = st_r.p4_latch;
                    end else begin
                        st_nxt.rdata = st_r.p4_s2;
                    end
                end
                DGP_P4_DIR_ADDR: begin
                    st_nxt.rdata = st_r.p4_dir;
                end
                DGP_P4_PU_ADDR: begin
                    st_nxt.rdata = st_r.p4_pu;
                end
                DGP_STBY_ADDR: begin
                    st_nxt.rdata = {7'h00, st_r.standby_pin_state_select};
                end
                default: begin
                    st_nxt.rdata = DGP_ZERO;
                end
            endcase
        end

        // Standby with select bit set floats every pin, direction ignored
        hiz = stop_watch_i & st_r.standby_pin_state_select;
        p4_dir_eff = st_r.p4_dir & ~DGP_P4_OD_MASK;

        // Drive value per pin: peripheral output wins over the latch
        for (int b = 0; b < DGP_W; b++) begin
            if (p3_periph_i.en[b]) begin
                v3[b] = p3_periph_i.val[b];
            end else begin
                v3[b] = st_r.p3_latch[b];
            end
            if (p4_periph_i.en[b]) begin
                v4[b] = p4_periph_i.val[b];
            end else begin
                v4[b] = st_r.p4_latch[b];
            end
        end

        // Port three: push-pull on every pin
        for (int b = 0; b < DGP_W; b++) begin
            st_nxt.p3_pins.out[b] = v3[b];
            if (hiz) begin
                st_nxt.p3_pins.oe[b] = 1'b0;
                st_nxt.p3_pins.pu[b] = st_r.p3_pu[b];
            end else begin
                st_nxt.p3_pins.oe[b] = p3_periph_i.en[b] | st_r.p3_dir[b];
                st_nxt.p3_pins.pu[b] = 1'b0;
            end
        end

        // Port four: open-drain pins only pull low and never get a pull-up
        for (int b = 0; b < DGP_W; b++) begin
            if (DGP_P4_OD_MASK[b]) begin
                st_nxt.p4_pins.out[b] = 1'b0;
                st_nxt.p4_pins.pu[b] = 1'b0;
                if (hiz) begin
                    st_nxt.p4_pins.oe[b] = 1'b0;
                end else begin
                    st_nxt.p4_pins.oe[b] = ~v4[b];
                end
            end else begin
                st_nxt.p4_pins.out[b] = v4[b];
                if (hiz) begin
                    st_nxt.p4_pins.oe[b] = 1'b0;
                    st_nxt.p4_pins.pu[b] = st_r.p4_pu[b];
                end else begin
                    st_nxt.p4_pins.oe[b] = p4_periph_i.en[b] | p4_dir_eff[b];
                    st_nxt.p4_pins.pu[b] = 1'b0;
                end
            end
        end

        // Input-configured port-four pins reach the interrupt circuits
        for (int b = 0; b < DGP_W; b++) begin
            if (DGP_P4_OD_MASK[b]) begin
                // Open-drain pins always read back, driver or not
                st_nxt.ext_int[b] = st_r.p4_s2[b];
            end else if (p4_dir_eff[b] | p4_periph_i.en[b]) begin
                st_nxt.ext_int[b] = 1'b0;
            end else begin
                st_nxt.ext_int[b] = st_r.p4_s2[b];
            end
        end
    end

    // Output latches stay out of the reset branch so they hold their content,
    // except the two open-drain bits which reset to one
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r.p4_latch[DGP_P4_OD_MSB:DGP_P4_OD_LSB] <=
                DGP_P4_LATCH_RST_OD[DGP_P4_OD_MSB:DGP_P4_OD_LSB];
            st_r.p3_dir <= DGP_DIR_RST;
            st_r.p4_dir <= DGP_DIR_RST;
            st_r.p3_pu <= DGP_PU_RST;
            st_r.p4_pu <= DGP_PU_RST;
            st_r.standby_pin_state_select <= 1'b0;
            st_r.p3_s1 <= DGP_ZERO;
            st_r.p3_s2 <= DGP_ZERO;
            st_r.p4_s1 <= DGP_ZERO;
            st_r.p4_s2 <= DGP_ZERO;
            st_r.rdata <= DGP_ZERO;
            st_r.p3_pins.out <= DGP_ZERO;
            st_r.p3_pins.oe <= DGP_ZERO;
            st_r.p3_pins.pu <= DGP_ZERO;
            st_r.p4_pins.out <= DGP_ZERO;
            st_r.p4_pins.oe <= DGP_ZERO;
            st_r.p4_pins.pu <= DGP_ZERO;
            st_r.ext_int <= DGP_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    assign p3_pins_o = st_r.p3_pins;
    assign p4_pins_o = st_r.p4_pins;
    assign p3_level_o = st_r.p3_s2;
    assign p4_level_o = st_r.p4_s2;
    assign ext_int_o = st_r.ext_int;

endmodule
`default_nettype wire

// File: dv/dgp_port_props.sv
/* Checker on the ports of dgp_port.
   Bound to every instance of the port block. */
`timescale 1ns/1ps
`default_nettype none
module dgp_port_props
    import dgp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic stop_watch_i,
    input wire dgp_periph_t p3_periph_i,
    input wire dgp_periph_t p4_periph_i,
    input wire dgp_pins_t p3_pins_o,
    input wire dgp_pins_t p4_pins_o
);
    logic sel_r;
    // Shadow of the standby select bit
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_r <= 1'b0;
        end else if (wr_i && addr_i == DGP_STBY_ADDR) begin
            sel_r <= wdata_i[DGP_SPL_BIT];
        end
    end
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside slot");
    a_od_low_nopu: assert property (((p4_pins_o.out | p4_pins_o.pu) & DGP_P4_OD_MASK) == 8'h00)
        else $error("open-drain drives high");
    a_periph_wins: assert property (!stop_watch_i |=> ((p3_pins_o.oe & $past(p3_periph_i.en)) ==
        $past(p3_periph_i.en)) && (((p3_pins_o.out ^ $past(p3_periph_i.val)) & $past(p3_periph_i.en)) == 8'h00))
        else $error("peripheral output lost");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |->
        (p3_pins_o.oe | p4_pins_o.oe | p3_pins_o.pu | p4_pins_o.pu) == 8'h00) else $error("pin active in reset");
    a_standby_float: assert property (stop_watch_i && sel_r |=> (p3_pins_o.oe | p4_pins_o.oe) == 8'h00)
        else $error("pin driven in standby");
    a_dir_drive: assert property (wr_i && addr_i == DGP_P4_DIR_ADDR ##1 !stop_watch_i && p4_periph_i.en == 8'h00
        |=> (p4_pins_o.oe & ~DGP_P4_OD_MASK) == ($past(wdata_i, 2) & ~DGP_P4_OD_MASK)) else $error("enable off");
    a_latch_drive: assert property (wr_i && addr_i == DGP_P3_DATA_ADDR ##1 !stop_watch_i && p3_periph_i.en == 8'h00
        |=> ((p3_pins_o.out ^ $past(wdata_i, 2)) & p3_pins_o.oe) == 8'h00) else $error("drive value off");
    a_od_from_latch: assert property (wr_i && addr_i == DGP_P4_DATA_ADDR ##1 !stop_watch_i && p4_periph_i.en == 8'h00
        |=> (p4_pins_o.oe & DGP_P4_OD_MASK) == (~$past(wdata_i, 2) & DGP_P4_OD_MASK)) else $error("open-drain off");
    c_standby: cover property (stop_watch_i && sel_r);
    c_periph: cover property (p3_periph_i.en != 8'h00 && !stop_watch_i);
    c_dir: cover property (wr_i && addr_i == DGP_P4_DIR_ADDR);
endmodule
bind dgp_port dgp_port_props u_props (.*);
`default_nettype wire

// File: dv/dgp_pin_model.sv
/* Far side of one 8-pin port: outside drivers and pull-ups.
   Combinational; the bench gives the outside levels. */
`timescale 1ns/1ps
`default_nettype none
module dgp_pin_model
    import dgp_pkg::*;
(
    input wire dgp_pins_t pins_i,
    input wire logic [7:0] ext_i,
    output logic [7:0] pin_o
);
    // Driven bits show the drive, released bits the pull-up or outside level
    assign pin_o = (pins_i.oe & pins_i.out) | (~pins_i.oe & (pins_i.pu | ext_i));
endmodule
`default_nettype wire

// File: dv/dgp_port_tb.sv
/* Bench for dgp_port: random port set-ups read back and checked.
   Uses dgp_pin_model on both ports. */
`timescale 1ns/1ps
`default_nettype none
module dgp_port_tb;
    import dgp_pkg::*;
    logic mclk_i = 0, rst_i, wr_i = 0, rd_i = 0, bitop_rd_i = 0, stop_watch_i = 0, s, t;
    logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, p3_pin_i, p4_pin_i, p3_level_o, p4_level_o, ext_int_o, x, o;
    logic [7:0] d[2], m[2], u[2], n[2], v[2], e[2] = '{8'h00, 8'h00};
    dgp_periph_t p3_periph_i = '0, p4_periph_i = '0;
    dgp_pins_t p3_pins_o, p4_pins_o;
    int n_fail = 0, cmp_count = 0;
    dgp_port u_dut (.*);
    dgp_pin_model u_m3 (.pins_i(p3_pins_o), .ext_i(e[0]), .pin_o(p3_pin_i));
    // Port four also feeds ext_int_o, so its plain inputs are checked there too
    dgp_pin_model u_m4 (.pins_i(p4_pins_o), .ext_i(e[1]), .pin_o(p4_pin_i));
    initial forever #5 mclk_i = ~mclk_i;
    task automatic end_sim;
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] w);
        cmp_count++;
        if (g !== w) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, g, w);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        addr_i <= a;
        wdata_i <= w;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic b, input logic [7:0] w, input logic [7:0] k = 8'hFF);
        addr_i <= a;
        rd_i <= 1'b1;
        bitop_rd_i <= b;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        bitop_rd_i <= 1'b0;
        #1 chk(rdata_o & k, w & k);
        @(posedge mclk_i);
    endtask
    // Expected pin levels from latch, direction, pull-up, outside level and peripheral
    function automatic logic [7:0] px(logic [7:0] d, m, u, e, o, n, v);
        logic [7:0] l, r;
        l = (n & v) | (~n & d);
        r = n | m;
        return (((l & r) | ((e | u) & ~r)) & ~o) | (l & e & o);
    endfunction
    task automatic rchk;
        rd(DGP_P3_DIR_ADDR, 1'b0, 8'h00);
        rd(DGP_P4_DIR_ADDR, 1'b0, 8'h00);
        rd(DGP_P4_PU_ADDR, 1'b0, 8'h00);
        rd(8'h20, 1'b0, 8'h00);
        $display("reset checks done");
    endtask
    initial begin
        rst_i <= 1'b1;
        void'($urandom(1280));
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        rd(DGP_P4_DATA_ADDR, 1'b1, 8'h0C, 8'h0C);
        rchk;
        for (int i = 0; i < 30; i++) begin
            s = 1'($urandom);
            t = 1'($urandom);
            for (int p = 0; p < 2; p++) begin
                {d[p], m[p], u[p], v[p]} = $urandom;
                n[p] = i[0] ? 8'($urandom) : 8'h00;
                if (i % 5 == 4) begin
                    m[p] = 8'h00;
                end
                e[p] <= 8'($urandom);
                wr(p ? DGP_P4_DATA_ADDR : DGP_P3_DATA_ADDR, d[p]);
                wr(p ? DGP_P4_DIR_ADDR : DGP_P3_DIR_ADDR, m[p]);
                wr(p ? DGP_P4_PU_ADDR : DGP_P3_PU_ADDR, u[p]);
            end
            wr(DGP_STBY_ADDR, 8'(s) << DGP_SPL_BIT);
            stop_watch_i <= t;
            p3_periph_i <= {n[0], v[0]};
            p4_periph_i <= {n[1], v[1]};
            repeat (5) @(posedge mclk_i);
            for (int p = 0; p < 2; p++) begin
                o = p ? DGP_P4_OD_MASK : 8'h00;
                x = (s && t) ? px(8'hFF, 8'h00, u[p], e[p], o, 8'h00, 8'h00) :
                    px(d[p], m[p], 8'h00, e[p], o, n[p], v[p]);
                rd(p ? DGP_P4_DATA_ADDR : DGP_P3_DATA_ADDR, 1'b0, x);
                rd(p ? DGP_P4_DATA_ADDR : DGP_P3_DATA_ADDR, 1'b1, d[p]);
                rd(p ? DGP_P4_DIR_ADDR : DGP_P3_DIR_ADDR, 1'b0, m[p] & ~o);
                chk(p ? p4_level_o : p3_level_o, x);
            end
            if (!(s && t)) begin
                chk(ext_int_o, x & (~(m[1] | n[1]) | DGP_P4_OD_MASK));
            end
            $display("iteration %0d done", i);
        end
        rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        rd(DGP_P4_DATA_ADDR, 1'b1, d[1] | 8'h0C);
        rchk;
        end_sim;
    end
    initial begin
        #100us;
        n_fail++;
        end_sim;
    end
endmodule
`default_nettype wire
